// ### logic/ast_pkg.sv
// package: register map, field layout and frame constants of the serial transmitter
package ast_pkg;

  // ************************************************************
  // register map (byte addresses, one aligned word each)
  // ************************************************************
  localparam logic [3:0] STATUS_OFS  = 4'h0;  // serial_status_register
  localparam logic [3:0] DATA_OFS    = 4'h4;  // serial_data_register
  localparam logic [3:0] CTRL1_OFS   = 4'h8;  // serial_control_first
  localparam logic [3:0] CTRL2_OFS   = 4'hc;  // enables and interrupt enables

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int STAT_TDE_POS  = 7;  // tx_buffer_empty_flag
  localparam int STAT_TC_POS   = 6;  // tx_complete_flag
  localparam int CTL1_T8_POS   = 6;  // ninth_tx_bit
  localparam int CTL1_WL_POS   = 4;  // word_length_select
  localparam int CTL2_TIE_POS  = 7;  // tx_empty_irq_enable
  localparam int CTL2_TX_COMPLETE_IRQ_ENABLE_POS = 6;  // tx_complete_irq_enable
  localparam int CTL2_TE_POS   = 3;  // transmitter_enable
  localparam int CTL2_RE_POS   = 2;  // receiver_enable
  localparam int CTL2_SBK_POS  = 0;  // send_break_bit

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] STATUS_RST = 8'hc0;
  localparam logic [7:0] CTRL1_RST  = 8'h00;
  localparam logic [7:0] CTRL2_RST  = 8'h00;

  // ************************************************************
  // frame layout
  // ************************************************************
  localparam logic [3:0] BITS_8     = 4'ha;  // start + 8 data + stop
  localparam logic [3:0] BITS_9     = 4'hb;  // start + 9 data + stop
  localparam int         SHIFT_W    = 11;

  // transmitter states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_PREAM = 4'h2,
    ST_DATA  = 4'h4,
    ST_BREAK = 4'h8
  } ast_state_type;

  // control fields held by the block
  typedef struct packed {
    logic ninth;
    logic wl9;
    logic tx_empty_irq_enable;
    logic tx_complete_irq_enable;
    logic te;
    logic re;
    logic send_break_bit;
  } ast_ctrl_type;

endpackage : ast_pkg

// ### logic/ast_tx.sv
// design: transmit half of an asynchronous serial interface behind a wishbone slave
//
// Operation
// - pin released when both directions disabled
// - enabled with nothing pending, line high
// - start bit drives line low
// - stop bit drives line high
// - nine bits when selected, ninth from control
// - idle character is full frame of ones
// - transmit timed by its own baud tick
// - enabling transmitter selects serial pin function
// - enabling transmitter sends idle frame first
// - empty flag cleared by status then data write
// - empty flag set when buffer drains; interrupt
// - write while busy goes to holding buffer
// - write while quiet starts at once, flag set
// - complete flag set after stop or break
// - complete flag cleared by same sequence
// - break frames sent while break bit set
// - break length follows word length
// - one mark bit after last break frame
// - enable toggle mid-frame queues idle frame
// - enable toggle discards holding buffer
`timescale 1ns/10ps
`default_nettype none

module ast_tx
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // transmit baud tick from the external generator
  input  wire logic        tx_tick_i,
  // cpu interrupt mask bit of the condition code register
  input  wire logic        cpu_imask_i,
  // serial pin
  output logic             serial_tx_o,
  output logic             serial_tx_oe_o,
  // interrupt request
  output logic             tx_irq_o
);

  // ************************************************************
  // bus decode
  // ************************************************************
  logic                       req;
  logic                       wr;
  logic                       rd;
  logic                       lane0;
  logic                       ack_q;
  logic [31:0]                rdat_q;
  ast_pkg::ast_ctrl_type      ctrl_q;
  logic                       tde_q;
  logic                       tc_q;
  logic                       armed_q;
  logic [8:0]                 hold_q;
  logic                       hold_full_q;
  logic [ast_pkg::SHIFT_W-1:0] shift_q;
  logic [3:0]                 bitcnt_q;
  ast_pkg::ast_state_type     state_q;
  logic                       pream_q;
  logic                       mark_q;
  logic                       lead_q;
  logic                       data_wr;
  logic                       stat_acc;
  logic                       clr_seq;
  logic                       frame_end;
  logic                       load_hold;
  logic                       te_rise;
  logic                       te_fall;
  logic [3:0]                 frame_bits;
  logic [7:0]                 status_v;
  logic [7:0]                 ctrl1_v;
  logic [7:0]                 ctrl2_v;

  // a request is served once; ack falls the cycle after it is given
  assign req      = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr       = req && wb_we_i;
  assign rd       = req && !wb_we_i;
  assign lane0    = wb_sel_i[0];
  assign data_wr  = wr && lane0 && (wb_adr_i == ast_pkg::DATA_OFS);
  // any read or write of the status word arms the clear sequence
  assign stat_acc = req && (wb_adr_i == ast_pkg::STATUS_OFS);
  assign clr_seq  = data_wr && armed_q;

  // frame length follows word length, for data and break alike
  assign frame_bits = ctrl_q.wl9 ? ast_pkg::BITS_9 : ast_pkg::BITS_8;

  // bit period ends on the last tick of a frame
  assign frame_end = tx_tick_i && (bitcnt_q == 4'h1)
                     && (state_q != ast_pkg::ST_IDLE);

  // holding buffer moves to shifter at frame end, or at once if quiet
  // never straight after a break frame: the trailing mark bit goes first
  assign load_hold = hold_full_q && ctrl_q.te && !ctrl_q.send_break_bit && !pream_q && !mark_q
                     && ((state_q == ast_pkg::ST_IDLE)
                         || (frame_end && (state_q != ast_pkg::ST_BREAK)));

  assign status_v = {tde_q, tc_q, 6'h00};
  assign ctrl1_v  = {1'b0, ctrl_q.ninth, 1'b0, ctrl_q.wl9, 4'h0};
  assign ctrl2_v  = {ctrl_q.tx_empty_irq_enable, ctrl_q.tx_complete_irq_enable, 2'b00, ctrl_q.te, ctrl_q.re, 1'b0, ctrl_q.send_break_bit};

  // te edges: rising sends an idle frame, falling drops the held word
  assign te_rise = wr && lane0 && (wb_adr_i == ast_pkg::CTRL2_OFS)
                   && wb_dat_i[ast_pkg::CTL2_TE_POS] && !ctrl_q.te;
  assign te_fall = wr && lane0 && (wb_adr_i == ast_pkg::CTRL2_OFS)
                   && !wb_dat_i[ast_pkg::CTL2_TE_POS] && ctrl_q.te;

  // ************************************************************
  // wishbone answer
  // ************************************************************
  // one wait state: ack in the cycle after the request is seen
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_q <= 1'b0;
    else
      ack_q <= req;
  end

  // read data is registered alongside ack; unmapped reads return zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdat_q <= 32'h0000_0000;
    else if (rd)
    begin
      unique case (wb_adr_i)
        ast_pkg::STATUS_OFS: rdat_q <= {24'h00_0000, status_v};
        ast_pkg::DATA_OFS:   rdat_q <= {23'h00_0000, hold_q};
        ast_pkg::CTRL1_OFS:  rdat_q <= {24'h00_0000, ctrl1_v};
        ast_pkg::CTRL2_OFS:  rdat_q <= {24'h00_0000, ctrl2_v};
        default:             rdat_q <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ************************************************************
  // control registers
  // ************************************************************
  // baud settings live outside; software keeps them steady while enabled
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_q <= '0;
    else if (wr && lane0 && (wb_adr_i == ast_pkg::CTRL1_OFS))
    begin
      ctrl_q.ninth <= wb_dat_i[ast_pkg::CTL1_T8_POS];
      ctrl_q.wl9   <= wb_dat_i[ast_pkg::CTL1_WL_POS];
    end
    else if (wr && lane0 && (wb_adr_i == ast_pkg::CTRL2_OFS))
    begin
      ctrl_q.tx_empty_irq_enable  <= wb_dat_i[ast_pkg::CTL2_TIE_POS];
      ctrl_q.tx_complete_irq_enable <= wb_dat_i[ast_pkg::CTL2_TX_COMPLETE_IRQ_ENABLE_POS];
      ctrl_q.te   <= wb_dat_i[ast_pkg::CTL2_TE_POS];
      ctrl_q.re   <= wb_dat_i[ast_pkg::CTL2_RE_POS];
      ctrl_q.send_break_bit  <= wb_dat_i[ast_pkg::CTL2_SBK_POS];
    end
  end

  // ************************************************************
  // status flags and clear sequence
  // ************************************************************
  // the sequence stays armed until the data write that completes it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      armed_q <= 1'b0;
    else if (stat_acc)
      armed_q <= 1'b1;
    else if (data_wr)
      armed_q <= 1'b0;
  end

  // empty flag: a set in the same cycle as the clear wins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tde_q <= ast_pkg::STATUS_RST[ast_pkg::STAT_TDE_POS];
    else if (load_hold || (data_wr && (state_q == ast_pkg::ST_IDLE) && !hold_full_q))
      tde_q <= 1'b1;
    else if (clr_seq)
      tde_q <= 1'b0;
  end

  // complete flag: set at end of every data or break frame
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tc_q <= ast_pkg::STATUS_RST[ast_pkg::STAT_TC_POS];
    else if (frame_end && ((state_q == ast_pkg::ST_DATA) || (state_q == ast_pkg::ST_BREAK)))
      tc_q <= 1'b1;
    else if (clr_seq)
      tc_q <= 1'b0;
  end

  // ************************************************************
  // holding buffer
  // ************************************************************
  // ninth bit is sampled with the word so a later control write cannot skew it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hold_q      <= 9'h000;
      hold_full_q <= 1'b0;
    end
    else if (data_wr)
    begin
      hold_q      <= {ctrl_q.ninth, wb_dat_i[7:0]};
      hold_full_q <= 1'b1;
    end
    else if (te_fall)
      hold_full_q <= 1'b0;
    else if (load_hold)
      hold_full_q <= 1'b0;
  end

  // ************************************************************
  // pending idle frame and trailing mark bit
  // ************************************************************
  // a rising enable queues one idle frame, sent when the line is free
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pream_q <= 1'b0;
    else if (te_rise)
      pream_q <= 1'b1;
    else if ((state_q == ast_pkg::ST_PREAM) && frame_end)
      pream_q <= 1'b0;
  end

  // the last break frame is followed by one mark bit before anything else
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mark_q <= 1'b0;
    else if ((state_q == ast_pkg::ST_BREAK) && frame_end && !ctrl_q.send_break_bit)
      mark_q <= 1'b1;
    else if (mark_q && tx_tick_i)
      mark_q <= 1'b0;
  end

  // a frame begun from idle waits for the next tick, so its first bit is a whole period
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lead_q <= 1'b0;
    else if (state_q == ast_pkg::ST_IDLE)
      lead_q <= 1'b1;
    else if (tx_tick_i)
      lead_q <= 1'b0;
  end

  // ************************************************************
  // transmit sequencer
  // ************************************************************
  // one bit leaves per baud tick; the shifter carries the stop bit in
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q  <= ast_pkg::ST_IDLE;
      shift_q  <= '1;
      bitcnt_q <= 4'h0;
    end
    else if (load_hold)
    begin
      state_q  <= ast_pkg::ST_DATA;
      bitcnt_q <= frame_bits;
      if (ctrl_q.wl9)
        shift_q <= {1'b1, hold_q, 1'b0};
      else
        shift_q <= {2'b11, hold_q[7:0], 1'b0};
    end
    else if ((state_q == ast_pkg::ST_IDLE) || frame_end)
    begin
      if (!ctrl_q.te || mark_q)
      begin
        state_q  <= ast_pkg::ST_IDLE;
        shift_q  <= '1;
        bitcnt_q <= 4'h0;
      end
      else if (ctrl_q.send_break_bit)
      begin
        state_q  <= ast_pkg::ST_BREAK;
        shift_q  <= '0;
        bitcnt_q <= frame_bits;
      end
      else if (pream_q && !((state_q == ast_pkg::ST_PREAM) && frame_end))
      begin
        state_q  <= ast_pkg::ST_PREAM;
        shift_q  <= '1;
        bitcnt_q <= frame_bits;
      end
      else
      begin
        state_q  <= ast_pkg::ST_IDLE;
        shift_q  <= '1;
        bitcnt_q <= 4'h0;
      end
    end
    else if (tx_tick_i && !lead_q)
    begin
      shift_q  <= {1'b1, shift_q[ast_pkg::SHIFT_W-1:1]};
      bitcnt_q <= bitcnt_q - 4'h1;
    end
  end

  // ************************************************************
  // pin and interrupt outputs
  // ************************************************************
  // line is high whenever nothing shifts; the mark bit is also high
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      serial_tx_o <= 1'b1;
    else if ((state_q == ast_pkg::ST_IDLE) || mark_q || lead_q)
      serial_tx_o <= 1'b1;
    else
      serial_tx_o <= shift_q[0];
  end

  // pin is ours while either direction is enabled
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      serial_tx_oe_o <= 1'b0;
    else
      serial_tx_oe_o <= ctrl_q.te || ctrl_q.re;
  end

  // level request, gated by the cpu interrupt mask
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tx_irq_o <= 1'b0;
    else
      tx_irq_o <= !cpu_imask_i && ((tde_q && ctrl_q.tx_empty_irq_enable) || (tc_q && ctrl_q.tx_complete_irq_enable));
  end

endmodule : ast_tx

`default_nettype wire

// ### dv/ast_tx_checker.sv
// checker: port assertions of the serial transmitter
`timescale 1ns/10ps
`default_nettype none

module ast_tx_checker
(
  // clock, reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // line side
  input wire logic        tx_tick_i,
  input wire logic        cpu_imask_i,
  input wire logic        serial_tx_o,
  input wire logic        serial_tx_oe_o,
  input wire logic        tx_irq_o
);
  // ****
  // helpers
  // ****
  logic want_q;  // pin enable implied by last control write
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ctl_wr_s;
    wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == ast_pkg::CTRL2_OFS;
  endsequence
  // kept here because the bus data moves on before the pin settles
  always_ff @(posedge clk_i)
  begin
    if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == ast_pkg::CTRL2_OFS)
      want_q <= wb_dat_i[ast_pkg::CTL2_TE_POS] | wb_dat_i[ast_pkg::CTL2_RE_POS];
  end
  ack_answer_a: assert property (req_s |=> wb_ack_o)
    else $error("no ack");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_quiet_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack unasked");
  hole_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[1:0] != 2'h0 |-> wb_dat_o == 32'h0)
    else $error("hole read");
  status_bits_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == ast_pkg::STATUS_OFS
    |-> wb_dat_o[31:8] == 24'h0 && wb_dat_o[5:0] == 6'h0) else $error("status bits");
  pin_enable_a: assert property (ctl_wr_s |-> ##[1:2] serial_tx_oe_o == want_q)
    else $error("pin enable");
  line_tick_a: assert property ($changed(serial_tx_o) |->
    $past(tx_tick_i, 1) || $past(tx_tick_i, 2) || $past(tx_tick_i, 3)) else $error("line moved");
  start_low_a: assert property ($fell(serial_tx_o) |-> !serial_tx_o [*6])
    else $error("short low");
  mark_hold_a: assert property ($rose(serial_tx_o) |-> serial_tx_o [*6])
    else $error("short high");
  irq_mask_a: assert property ($past(cpu_imask_i) |-> !tx_irq_o)
    else $error("masked irq");
endmodule : ast_tx_checker

`default_nettype wire

// ### dv/ast_rx_model.sv
// partner: remote receiver decoding frames from the serial line
`timescale 1ns/10ps
`default_nettype none

module ast_rx_model
(
  // clock, reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // bit timing and line
  input  wire logic       tick_i,
  input  wire logic       line_i,
  input  wire logic       wl9_i,
  // results
  output logic      [8:0] word_o,
  output logic            got_o,
  output logic            brk_o
);
  logic [3:0] ph_q;     // clocks to the mid-bit sample
  logic [3:0] cnt_q;    // bit position, 0 while hunting
  logic [8:0] sh_q;
  logic       armed_q;  // a mark was seen, so a fall is a start
  logic [3:0] zr_q;     // low samples while hunting, counts back-to-back breaks
  logic [8:0] word_w;
  assign word_w = {wl9_i & sh_q[8], sh_q[7:0]};
  // sample mid-bit; after a break a mark is needed before a new start
  always_ff @(posedge clk_i)
  begin
    got_o <= 1'b0;
    brk_o <= 1'b0;
    ph_q  <= tick_i ? 4'h4 : ph_q - {3'h0, ph_q != 4'h0};
    if (rst_i)
    begin
      cnt_q   <= 4'h0;
      armed_q <= 1'b0;
      zr_q    <= 4'h0;
    end
    else if (ph_q == 4'h1)
    begin
      if (cnt_q == 4'h0)
      begin
        armed_q <= line_i;
        if (!line_i && armed_q)
          cnt_q <= 4'h1;
        // a line held low with no mark in between is one more break frame
        if (line_i || armed_q || zr_q == (wl9_i ? 4'ha : 4'h9))
          zr_q <= 4'h0;
        else
          zr_q <= zr_q + 4'h1;
        if (!line_i && !armed_q && zr_q == (wl9_i ? 4'ha : 4'h9))
          brk_o <= 1'b1;
      end
      else if (cnt_q <= (wl9_i ? 4'h9 : 4'h8))
      begin
        sh_q[cnt_q - 4'h1] <= line_i;
        cnt_q              <= cnt_q + 4'h1;
      end
      else
      begin
        cnt_q   <= 4'h0;
        zr_q    <= 4'h0;
        armed_q <= line_i;
        got_o   <= line_i;
        brk_o   <= !line_i && word_w == 9'h0;
        word_o  <= word_w;
      end
    end
  end
endmodule : ast_rx_model

`default_nettype wire

// ### dv/ast_tx_test.sv
// testbench: bus, framing, flags, interrupt and break of the serial transmitter
`timescale 1ns/10ps
`default_nettype none

module ast_tx_test;
  typedef struct packed {logic wl9; logic ninth; logic [7:0] d; logic [8:0] e;} ast_row_type;
  ast_row_type rows [4] = '{'{1'b0, 1'b0, 8'h55, 9'h055}, '{1'b0, 1'b1, 8'h80, 9'h080},
                            '{1'b1, 1'b1, 8'h01, 9'h101}, '{1'b1, 1'b0, 8'hff, 9'h0ff}};
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        we    = 1'b0;
  logic        tick  = 1'b0;
  logic        imask = 1'b0;
  logic        wl9   = 1'b0;
  logic [2:0]  div   = 3'h0;
  logic [3:0]  adr   = 4'h0;
  logic [31:0] wdat  = 32'h0;
  logic [31:0] rdat, rd;
  logic [8:0]  word;
  logic        ack, txd, oe, irq, got, brk;
  logic [8:0]  rxq [$];
  int          brks  = 0;
  int          wt;
  int          err_count = 0;
  int          checked   = 0;

  ast_tx u_ast_tx (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .tx_tick_i(tick), .cpu_imask_i(imask), .serial_tx_o(txd), .serial_tx_oe_o(oe), .tx_irq_o(irq));
  ast_rx_model u_ast_rx_model (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick), .line_i(txd),
    .wl9_i(wl9), .word_o(word), .got_o(got), .brk_o(brk));

  always #2 clk_i = ~clk_i;
  // tick every 8 clocks; results are queued so no pulse is lost during bus work
  always @(posedge clk_i)
  begin
    div  <= div + 3'h1;
    tick <= div == 3'h7;
    if (got === 1'b1)
      rxq.push_back(word);
    if (brk === 1'b1)
      brks++;
  end

  // ****
  // tasks
  // ****
  task automatic note(input string m);
    err_count++;
    $display("[ERR] %0t %s", $time, m);
  endtask : note
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
      note("register value");
  endtask : chk_reg
  task automatic chk_word(input logic [8:0] g, input logic [8:0] e);
    checked++;
    if (g !== e)
      note("received word");
  endtask : chk_word
  task automatic chk_bit(input logic g, input logic e);
    checked++;
    if (g !== e)
      note("flag level");
  endtask : chk_bit
  // one classic cycle; wait for ack, then release
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h0, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    rd = rdat;
    cyc <= 1'b0;
    if (ack !== 1'b1)
      note("no bus answer");
  endtask : wb
  task automatic wait_rx(input int k);
    wt = 0;
    while (rxq.size() < k && wt < 2000)
    begin
      @(posedge clk_i);
      wt++;
    end
    if (rxq.size() < k)
      note("no frame");
  endtask : wait_rx
  task automatic complete_run;
    if (err_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  // cut a hang short
  initial
  begin
    repeat (20000) @(posedge clk_i);
    note("watchdog");
    complete_run();
  end

  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, ast_pkg::STATUS_OFS, 8'h00);
    chk_reg(rd, {24'h0, ast_pkg::STATUS_RST});
    wb(1'b0, 4'h1, 8'h00);
    chk_reg(rd, 32'h0);
    wb(1'b1, ast_pkg::CTRL2_OFS, 8'h08);
    foreach (rows[i])
    begin
      wl9 <= rows[i].wl9;
      wb(1'b1, ast_pkg::CTRL1_OFS, {1'b0, rows[i].ninth, 1'b0, rows[i].wl9, 4'h0});
      wb(1'b0, ast_pkg::STATUS_OFS, 8'h00);
      wb(1'b1, ast_pkg::DATA_OFS, rows[i].d);
      wait_rx(1);
      if (i == 0)
        chk_bit(wt > 120, 1'b1);
      chk_word(rxq.pop_front(), rows[i].e);
    end
    chk_bit(oe, 1'b1);
    // let the stop bit end before reading the flags
    repeat (16) @(posedge clk_i);
    wb(1'b0, ast_pkg::STATUS_OFS, 8'h00);
    chk_reg(rd, 32'hc0);
    wb(1'b1, ast_pkg::DATA_OFS, 8'ha5);
    wb(1'b0, ast_pkg::STATUS_OFS, 8'h00);
    chk_reg(rd, 32'h80);
    wb(1'b1, ast_pkg::DATA_OFS, 8'h3c);
    wb(1'b0, ast_pkg::STATUS_OFS, 8'h00);
    chk_reg(rd, 32'h00);
    wait_rx(2);
    chk_word(rxq.pop_front(), 9'h0a5);
    chk_word(rxq.pop_front(), 9'h03c);
    repeat (16) @(posedge clk_i);
    wb(1'b1, ast_pkg::CTRL2_OFS, 8'h48);
    repeat (3) @(posedge clk_i);
    chk_bit(irq, 1'b1);
    imask <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk_bit(irq, 1'b0);
    imask <= 1'b0;
    wb(1'b1, ast_pkg::CTRL2_OFS, 8'h88);
    repeat (3) @(posedge clk_i);
    chk_bit(irq, 1'b1);
    wb(1'b1, ast_pkg::CTRL1_OFS, 8'h00);
    wl9 <= 1'b0;
    wb(1'b1, ast_pkg::CTRL2_OFS, 8'h09);
    wt = 0;
    while (brks < 2 && wt < 2000)
    begin
      @(posedge clk_i);
      wt++;
    end
    chk_bit(brks >= 2, 1'b1);
    wb(1'b1, ast_pkg::CTRL2_OFS, 8'h08);
    wb(1'b0, ast_pkg::STATUS_OFS, 8'h00);
    wb(1'b1, ast_pkg::DATA_OFS, 8'h96);
    wait_rx(1);
    chk_word(rxq.pop_front(), 9'h096);
    // enable toggle while a word waits: the held word must never appear
    repeat (16) @(posedge clk_i);
    wb(1'b1, ast_pkg::DATA_OFS, 8'h11);
    wb(1'b1, ast_pkg::DATA_OFS, 8'h22);
    wb(1'b1, ast_pkg::CTRL2_OFS, 8'h00);
    wb(1'b1, ast_pkg::CTRL2_OFS, 8'h08);
    wait_rx(1);
    chk_word(rxq.pop_front(), 9'h011);
    repeat (240) @(posedge clk_i);
    chk_bit(rxq.size() == 0, 1'b1);
    // enable toggle mid-frame: an idle frame comes before the next word
    wb(1'b1, ast_pkg::DATA_OFS, 8'h33);
    wb(1'b1, ast_pkg::CTRL2_OFS, 8'h00);
    wb(1'b1, ast_pkg::CTRL2_OFS, 8'h08);
    wb(1'b1, ast_pkg::DATA_OFS, 8'h44);
    wait_rx(1);
    chk_word(rxq.pop_front(), 9'h033);
    wait_rx(1);
    chk_bit(wt > 120, 1'b1);
    chk_word(rxq.pop_front(), 9'h044);
    wb(1'b1, ast_pkg::CTRL2_OFS, 8'h00);
    repeat (3) @(posedge clk_i);
    chk_bit(oe, 1'b0);
    complete_run();
  end
endmodule : ast_tx_test

bind ast_tx ast_tx_checker u_ast_tx_checker (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_tick_i(tx_tick_i),
  .cpu_imask_i(cpu_imask_i), .serial_tx_o(serial_tx_o), .serial_tx_oe_o(serial_tx_oe_o),
  .tx_irq_o(tx_irq_o));

`default_nettype wire
